// ===== pkg/pam_pkg.sv
package pam_pkg;
	// ------------------------------------------------------------
	// Register map (byte addresses)
	// ------------------------------------------------------------
	localparam logic [7:0] PAM_PORT_C_ALT_SELECT_OFS = 8'h00;
	localparam logic [7:0] PAM_PORT_E_ALT_SELECT_OFS = 8'h04;
	localparam logic [7:0] PAM_INTERFACE_CONFIG_OFS = 8'h08;
	localparam logic [7:0] PAM_ENDPOINT_BUFFER_CONFIG_OFS = 8'h0c;
	localparam logic [7:0] PAM_PORT_C_OUT_OFS = 8'h10;
	localparam logic [7:0] PAM_PORT_C_OE_OFS = 8'h14;
	localparam logic [7:0] PAM_PORT_D_OUT_OFS = 8'h18;
	localparam logic [7:0] PAM_PORT_D_OE_OFS = 8'h1c;
	localparam logic [7:0] PAM_PORT_E_OUT_OFS = 8'h20;
	localparam logic [7:0] PAM_PORT_E_OE_OFS = 8'h24;
	localparam logic [7:0] PAM_PIN_C_OFS = 8'h28;
	localparam logic [7:0] PAM_PIN_D_OFS = 8'h2c;
	localparam logic [7:0] PAM_PIN_E_OFS = 8'h30;
	// ------------------------------------------------------------
	// Fields and reset values
	// ------------------------------------------------------------
	localparam logic [7:0] PAM_ALT_SELECT_RST = 8'h00;
	localparam logic [1:0] PAM_IFCFG_PORTS = 2'h0;
	localparam logic [1:0] PAM_IFCFG_RST = 2'h0;
	localparam logic [3:0] PAM_EP_WIDE_RST = 4'h0;
	localparam logic [7:0] PAM_PORT_RST = 8'h00;
	localparam int PAM_PORT_E_TIMER_BITS = 3;
	localparam logic [1:0] PAM_RESP_OKAY = 2'b00;
	localparam logic [1:0] PAM_RESP_SLVERR = 2'b10;
	// Timer operating mode in which the counter splits into two bytes
	localparam logic [1:0] PAM_TIMER_MODE_SPLIT = 2'h3;
endpackage

// ===== pkg/pam_pulse_if.sv
`timescale 1ns/10ps
interface pam_pulse_if;
	logic [2:0] ovf;
	logic [2:0] pulse;
	modport src (input ovf, output pulse);
	modport dst (output ovf, input pulse);
endinterface

// ===== hdl/pam_pulse_gen.sv
`timescale 1ns/10ps
module pam_pulse_gen
	import pam_pkg::*;
(
	input wire logic sys_clk, // Core clock
	input wire logic rst, // Synchronous reset
	input wire logic processor_clock_output_en, // One pulse per processor clock output cycle
	pam_pulse_if.src pif // Overflow events in, pulses out
);
	// ------------------------------------------------------------
	// Timer overflow stretch to one processor clock output cycle
	// ------------------------------------------------------------
	logic [2:0] pend_q;
	logic [2:0] pulse_q;
	genvar g;
	generate
		for (g = 0; g < PAM_PORT_E_TIMER_BITS; g++) begin : g_t
			// Overflow held until the next output-clock cycle starts
			always_ff @(posedge sys_clk) begin
				if (rst) begin
					pend_q[g] <= 1'b0;
				end else if (pif.ovf[g]) begin
					pend_q[g] <= 1'b1;
				end else if (processor_clock_output_en) begin
					pend_q[g] <= 1'b0;
				end
			end
			// Only the latched overflow is sent, so one caught on a strobe edge never gives two cycles
			always_ff @(posedge sys_clk) begin
				if (rst) begin
					pulse_q[g] <= 1'b0;
				end else if (processor_clock_output_en) begin
					pulse_q[g] <= pend_q[g];
				end
			end
		end
	endgenerate
	assign pif.pulse = pulse_q;
endmodule // pam_pulse_gen

// ===== hdl/pam_mux_top.sv
`timescale 1ns/10ps
// Function
// - Port C bits 5 to 7 carry the port bit or waveform address bit, chosen by port_c_alt_select.
// - A port C pin in alternate function is driven as an output of one waveform address bit.
// - In general port function each port C, D, E pin is a software-controlled bidirectional bit.
// - Port D switches to data bus bits 8 to 15 by interface_config_field and any of the four endpoint wide bits.
// - In data bus function each port D pin is a bidirectional line of the shared data bus.
// - Port E bits 0 to 2 carry the port bit or a timer pulse, chosen by port_e_alt_select.
// - The timer 0 pulse is high for exactly one processor clock output cycle per overflow.
// - In split mode the timer 0 pulse comes from the low-byte counter overflow.
// - The timer 1 pulse is one output-clock cycle per overflow, low-byte counter in split mode.
// - The timer 2 pulse is high for one processor clock output cycle per timer 2 overflow.
// - Port C bits 0 to 4 are selected the same way by their own alternate-select bits.
module pam_mux_top
	import pam_pkg::*;
(
	input wire logic sys_clk, // 200 MHz clock
	input wire logic rst, // Synchronous reset, active high
	input wire logic [31:0] s_axi_awaddr, // Write address
	input wire logic s_axi_awvalid, // Write address valid
	output logic s_axi_awready, // Write address ready
	input wire logic [31:0] s_axi_wdata, // Write data
	input wire logic [3:0] s_axi_wstrb, // Write strobes
	input wire logic s_axi_wvalid, // Write data valid
	output logic s_axi_wready, // Write data ready
	output logic [1:0] s_axi_bresp, // Write response
	output logic s_axi_bvalid, // Write response valid
	input wire logic s_axi_bready, // Write response ready
	input wire logic [31:0] s_axi_araddr, // Read address
	input wire logic s_axi_arvalid, // Read address valid
	output logic s_axi_arready, // Read address ready
	output logic [31:0] s_axi_rdata, // Read data
	output logic [1:0] s_axi_rresp, // Read response
	output logic s_axi_rvalid, // Read data valid
	input wire logic s_axi_rready, // Read data ready
	input wire logic processor_clock_output_en, // Processor clock output cycle strobe
	input wire logic [8:0] waveform_addr_out, // Waveform address, bits 0 to 7 used here
	input wire logic [15:8] shared_data_bus_o, // Data bus upper byte, driven value
	input wire logic shared_data_bus_oe, // Data bus drives its lines
	output logic [15:8] shared_data_bus_i, // Data bus upper byte, pin level
	input wire logic [1:0] timer0_mode, // Timer 0 operating mode
	input wire logic timer0_ovf_full, // Timer 0 full-count overflow
	input wire logic timer0_ovf_low, // Timer 0 low-byte overflow
	input wire logic [1:0] timer1_mode, // Timer 1 operating mode
	input wire logic timer1_ovf_full, // Timer 1 full-count overflow
	input wire logic timer1_ovf_low, // Timer 1 low-byte overflow
	input wire logic timer2_ovf, // Timer 2 overflow
	output logic [2:0] timer_overflow_pulses, // Timer 0..2 pulses, internal view
	input wire logic [7:0] port_c_in, // Port C pin levels
	output logic [7:0] port_c_out, // Port C pin drive values
	output logic [7:0] port_c_oe, // Port C output enables
	input wire logic [7:0] port_d_in, // Port D pin levels
	output logic [7:0] port_d_out, // Port D pin drive values
	output logic [7:0] port_d_oe, // Port D output enables
	input wire logic [7:0] port_e_in, // Port E pin levels
	output logic [7:0] port_e_out, // Port E pin drive values
	output logic [7:0] port_e_oe // Port E output enables
);
	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	logic [7:0] port_c_alt_select_q;
	logic [7:0] port_e_alt_select_q;
	logic [1:0] interface_config_field_q;
	logic [3:0] endpoint_buffer_config_q;
	logic [7:0] pc_out_q;
	logic [7:0] pc_oe_q;
	logic [7:0] pd_out_q;
	logic [7:0] pd_oe_q;
	logic [7:0] pe_out_q;
	logic [7:0] pe_oe_q;
	logic [7:0] aw_q;
	logic aw_have_q;
	logic [31:0] w_q;
	logic [3:0] ws_q;
	logic w_have_q;
	logic bvalid_q;
	logic rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0] rresp_q;
	logic [1:0] bresp_q;
	logic [7:0] pc_out_d;
	logic [7:0] pc_oe_d;
	logic [7:0] pd_out_d;
	logic [7:0] pd_oe_d;
	logic [7:0] pe_out_d;
	logic [7:0] pe_oe_d;
	logic data_bus_on;
	logic do_write;
	logic [2:0] pulses;

	// Byte-lane merge of a write into an eight-bit register
	function automatic logic [7:0] wr8(input logic [7:0] old, input logic [31:0] d, input logic [3:0] s);
		wr8 = s[0] ? d[7:0] : old;
	endfunction

	// Whether an address hits a mapped register
	function automatic logic mapped(input logic [7:0] a);
		mapped = (a[1:0] == 2'b00) && (a <= PAM_PIN_E_OFS);
	endfunction

	// Overflow that feeds a timer pulse; in split mode the low byte counts alone
	function automatic logic ovf_pick(input logic [1:0] mode, input logic full, input logic low);
		ovf_pick = (mode == PAM_TIMER_MODE_SPLIT) ? low : full;
	endfunction

	// ------------------------------------------------------------
	// AXI4-Lite write channel
	// ------------------------------------------------------------
	assign s_axi_awready = !aw_have_q && !bvalid_q;
	assign s_axi_wready = !w_have_q && !bvalid_q;
	assign do_write = aw_have_q && w_have_q && !bvalid_q;

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			aw_have_q <= 1'b0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_have_q <= 1'b1;
		end else if (do_write) begin
			aw_have_q <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			aw_q <= 8'h00;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_q <= s_axi_awaddr[7:0];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			w_have_q <= 1'b0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_have_q <= 1'b1;
		end else if (do_write) begin
			w_have_q <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			w_q <= 32'h0000_0000;
			ws_q <= 4'h0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_q <= s_axi_wdata;
			ws_q <= s_axi_wstrb;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			bvalid_q <= 1'b0;
		end else if (do_write) begin
			bvalid_q <= 1'b1;
		end else if (s_axi_bready) begin
			bvalid_q <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			bresp_q <= PAM_RESP_OKAY;
		end else if (do_write) begin
			bresp_q <= mapped(aw_q) ? PAM_RESP_OKAY : PAM_RESP_SLVERR;
		end
	end
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;

	// ------------------------------------------------------------
	// Configuration registers
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			port_c_alt_select_q <= PAM_ALT_SELECT_RST;
		end else if (do_write && ws_q[0] && (aw_q == PAM_PORT_C_ALT_SELECT_OFS)) begin
			port_c_alt_select_q <= w_q[7:0];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			port_e_alt_select_q <= PAM_ALT_SELECT_RST;
		end else if (do_write && ws_q[0] && (aw_q == PAM_PORT_E_ALT_SELECT_OFS)) begin
			port_e_alt_select_q <= w_q[7:0];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			interface_config_field_q <= PAM_IFCFG_RST;
		end else if (do_write && ws_q[0] && (aw_q == PAM_INTERFACE_CONFIG_OFS)) begin
			interface_config_field_q <= w_q[1:0];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			endpoint_buffer_config_q <= PAM_EP_WIDE_RST;
		end else if (do_write && ws_q[0] && (aw_q == PAM_ENDPOINT_BUFFER_CONFIG_OFS)) begin
			endpoint_buffer_config_q <= w_q[3:0];
		end
	end

	// Software port data and direction
	always_comb begin
		pc_out_d = pc_out_q;
		pc_oe_d = pc_oe_q;
		pd_out_d = pd_out_q;
		pd_oe_d = pd_oe_q;
		pe_out_d = pe_out_q;
		pe_oe_d = pe_oe_q;
		if (do_write) begin
			case (aw_q)
				PAM_PORT_C_OUT_OFS: pc_out_d = wr8(pc_out_q, w_q, ws_q);
				PAM_PORT_C_OE_OFS: pc_oe_d = wr8(pc_oe_q, w_q, ws_q);
				PAM_PORT_D_OUT_OFS: pd_out_d = wr8(pd_out_q, w_q, ws_q);
				PAM_PORT_D_OE_OFS: pd_oe_d = wr8(pd_oe_q, w_q, ws_q);
				PAM_PORT_E_OUT_OFS: pe_out_d = wr8(pe_out_q, w_q, ws_q);
				PAM_PORT_E_OE_OFS: pe_oe_d = wr8(pe_oe_q, w_q, ws_q);
				default: ;
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			pc_out_q <= PAM_PORT_RST;
			pc_oe_q <= PAM_PORT_RST;
			pd_out_q <= PAM_PORT_RST;
			pd_oe_q <= PAM_PORT_RST;
			pe_out_q <= PAM_PORT_RST;
			pe_oe_q <= PAM_PORT_RST;
		end else begin
			pc_out_q <= pc_out_d;
			pc_oe_q <= pc_oe_d;
			pd_out_q <= pd_out_d;
			pd_oe_q <= pd_oe_d;
			pe_out_q <= pe_out_d;
			pe_oe_q <= pe_oe_d;
		end
	end

	// ------------------------------------------------------------
	// AXI4-Lite read channel
	// ------------------------------------------------------------
	assign s_axi_arready = !rvalid_q;

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			rvalid_q <= 1'b0;
			rresp_q <= PAM_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rvalid_q <= 1'b1;
			rresp_q <= mapped(s_axi_araddr[7:0]) ? PAM_RESP_OKAY : PAM_RESP_SLVERR;
		end else if (s_axi_rready) begin
			rvalid_q <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			rdata_q <= 32'h0000_0000;
		end else if (s_axi_arvalid && s_axi_arready) begin
			case (s_axi_araddr[7:0])
				PAM_PORT_C_ALT_SELECT_OFS: rdata_q <= {24'h000000, port_c_alt_select_q};
				PAM_PORT_E_ALT_SELECT_OFS: rdata_q <= {24'h000000, port_e_alt_select_q};
				PAM_INTERFACE_CONFIG_OFS: rdata_q <= {30'h00000000, interface_config_field_q};
				PAM_ENDPOINT_BUFFER_CONFIG_OFS: rdata_q <= {28'h0000000, endpoint_buffer_config_q};
				PAM_PORT_C_OUT_OFS: rdata_q <= {24'h000000, pc_out_q};
				PAM_PORT_C_OE_OFS: rdata_q <= {24'h000000, pc_oe_q};
				PAM_PORT_D_OUT_OFS: rdata_q <= {24'h000000, pd_out_q};
				PAM_PORT_D_OE_OFS: rdata_q <= {24'h000000, pd_oe_q};
				PAM_PORT_E_OUT_OFS: rdata_q <= {24'h000000, pe_out_q};
				PAM_PORT_E_OE_OFS: rdata_q <= {24'h000000, pe_oe_q};
				PAM_PIN_C_OFS: rdata_q <= {24'h000000, port_c_in};
				PAM_PIN_D_OFS: rdata_q <= {24'h000000, port_d_in};
				PAM_PIN_E_OFS: rdata_q <= {24'h000000, port_e_in};
				default: rdata_q <= 32'h0000_0000;
			endcase
		end
	end
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;

	// ------------------------------------------------------------
	// Timer overflow pulses
	// ------------------------------------------------------------
	pam_pulse_if pif ();
	assign pif.ovf[0] = ovf_pick(timer0_mode, timer0_ovf_full, timer0_ovf_low);
	assign pif.ovf[1] = ovf_pick(timer1_mode, timer1_ovf_full, timer1_ovf_low);
	assign pif.ovf[2] = timer2_ovf;

	pam_pulse_gen i_pam_pulse_gen (
		.sys_clk(sys_clk),
		.rst(rst),
		.processor_clock_output_en(processor_clock_output_en),
		.pif(pif.src)
	);
	assign pulses = pif.pulse;
	assign timer_overflow_pulses = pulses;

	// ------------------------------------------------------------
	// Pin multiplexing
	// ------------------------------------------------------------
	// Upper data bus needs a non-port interface mode and a wide endpoint
	assign data_bus_on = (interface_config_field_q != PAM_IFCFG_PORTS) && (|endpoint_buffer_config_q);
	assign shared_data_bus_i = port_d_in;

	genvar i;
	generate
		for (i = 0; i < 8; i++) begin : g_pin
			always_comb begin
				if (port_c_alt_select_q[i]) begin
					port_c_out[i] = waveform_addr_out[i];
					port_c_oe[i] = 1'b1;
				end else begin
					port_c_out[i] = pc_out_q[i];
					port_c_oe[i] = pc_oe_q[i];
				end
			end
			always_comb begin
				if (data_bus_on) begin
					port_d_out[i] = shared_data_bus_o[8 + i];
					port_d_oe[i] = shared_data_bus_oe;
				end else begin
					port_d_out[i] = pd_out_q[i];
					port_d_oe[i] = pd_oe_q[i];
				end
			end
			if (i < PAM_PORT_E_TIMER_BITS) begin : g_e_alt
				always_comb begin
					if (port_e_alt_select_q[i]) begin
						port_e_out[i] = pulses[i];
						port_e_oe[i] = 1'b1;
					end else begin
						port_e_out[i] = pe_out_q[i];
						port_e_oe[i] = pe_oe_q[i];
					end
				end
			end else begin : g_e_port
				assign port_e_out[i] = pe_out_q[i];
				assign port_e_oe[i] = pe_oe_q[i];
			end
		end
	endgenerate
endmodule // pam_mux_top

// ===== tb/pam_mux_monitor.sv
`timescale 1ns/10ps
module pam_mux_monitor
	import pam_pkg::*;
(
	input wire logic sys_clk, // Clock
	input wire logic rst, // Reset
	input wire logic s_axi_awvalid, // AW valid
	input wire logic s_axi_awready, // AW ready
	input wire logic s_axi_wvalid, // W valid
	input wire logic s_axi_wready, // W ready
	input wire logic [1:0] s_axi_bresp, // B code
	input wire logic s_axi_bvalid, // B valid
	input wire logic s_axi_bready, // B ready
	input wire logic s_axi_arvalid, // AR valid
	input wire logic s_axi_arready, // AR ready
	input wire logic [31:0] s_axi_rdata, // R data
	input wire logic s_axi_rvalid, // R valid
	input wire logic s_axi_rready, // R ready
	input wire logic processor_clock_output_en, // Output clock strobe
	input wire logic [2:0] timer_overflow_pulses, // Pulses
	input wire logic [7:0] port_d_in, // Port D levels
	input wire logic [15:8] shared_data_bus_i, // Bus levels
	input wire logic [7:0] port_c_oe, // Port C enables
	input wire logic [7:0] port_d_oe, // Port D enables
	input wire logic [7:0] port_e_oe // Port E enables
);
	// ------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	property p_bvalid_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
	a_bvalid_hold: assert property (p_bvalid_hold) else $error("write response dropped early");
	property p_rvalid_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
	a_rvalid_hold: assert property (p_rvalid_hold) else $error("read response dropped early");
	property p_aw_refused; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
	a_aw_refused: assert property (p_aw_refused) else $error("write taken while response pending");
	property p_ar_refused; s_axi_rvalid |-> !s_axi_arready; endproperty
	a_ar_refused: assert property (p_ar_refused) else $error("read taken while response pending");
	property p_wr_answer; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:3] s_axi_bvalid; endproperty
	a_wr_answer: assert property (p_wr_answer) else $error("write response late");
	property p_rd_answer; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
	a_rd_answer: assert property (p_rd_answer) else $error("read response late");
	property p_pulse_step; !processor_clock_output_en |=> $stable(timer_overflow_pulses); endproperty
	a_pulse_step: assert property (p_pulse_step) else $error("pulse moved off output clock");
	property p_bus_in; port_d_in == shared_data_bus_i; endproperty
	a_bus_in: assert property (p_bus_in) else $error("bus input differs from pins");
	property p_reset; disable iff (1'h0) rst |=> port_c_oe == 8'h00 && port_d_oe == 8'h00 && port_e_oe == 8'h00
		&& !s_axi_bvalid && !s_axi_rvalid; endproperty
	a_reset: assert property (p_reset) else $error("pins not released by reset");
	c_write: cover property (s_axi_bvalid && s_axi_bready);
	c_read: cover property (s_axi_rvalid && s_axi_rready);
	c_pulse: cover property ($rose(timer_overflow_pulses[0]));
endmodule // pam_mux_monitor
bind pam_mux_top pam_mux_monitor i_pam_mux_monitor (.sys_clk, .rst, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
	.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
	.s_axi_rvalid, .s_axi_rready, .processor_clock_output_en, .timer_overflow_pulses, .port_d_in, .shared_data_bus_i, .port_c_oe,
	.port_d_oe, .port_e_oe);

// ===== tb/pam_board_port.sv
`timescale 1ns/10ps
module pam_board_port (
	input wire logic [7:0] dev_out, // Device drive values
	input wire logic [7:0] dev_oe, // Device drive enables
	input wire logic [7:0] ext_val, // Board drive values
	input wire logic [7:0] ext_en, // Board drive enables
	output logic [7:0] pin_level // Resolved levels
);
	// Pull-ups hold idle pins high; two drivers clash to unknown
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			case ({dev_oe[i], ext_en[i]})
				2'h2: pin_level[i] = dev_out[i];
				2'h1: pin_level[i] = ext_val[i];
				2'h0: pin_level[i] = 1'h1;
				default: pin_level[i] = 1'hx;
			endcase
		end
	end
endmodule // pam_board_port

// ===== tb/port_alternate_function_mux_tb.sv
`timescale 1ns/10ps
module port_alternate_function_mux_tb
	import pam_pkg::*;
;
	typedef struct {logic [7:0] a; logic [31:0] d; logic [1:0] r; logic [31:0] q;} pam_row_t;
	logic sys_clk = 1'h0;
	logic rst = 1'h1;
	logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, s_axi_rdata, q;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic [1:0] s_axi_bresp, s_axi_rresp, r, timer0_mode = 2'h0, timer1_mode = 2'h0, ce_cnt = 2'h0;
	logic processor_clock_output_en = 1'h0, shared_data_bus_oe = 1'h1, timer2_ovf = 1'h0;
	logic timer0_ovf_full = 1'h0, timer0_ovf_low = 1'h0, timer1_ovf_full = 1'h0, timer1_ovf_low = 1'h0;
	logic [8:0] waveform_addr_out = 9'h13c;
	logic [15:8] shared_data_bus_o = 8'h96, shared_data_bus_i;
	logic [2:0] timer_overflow_pulses;
	logic [7:0] port_c_in, port_c_out, port_c_oe, port_d_in, port_d_out, port_d_oe, port_e_in, port_e_out, port_e_oe;
	logic [7:0] ext_val = 8'h69, ext_en = 8'h00;
	int n_mismatch = 0, checks = 0, cyc = 0;
	pam_row_t rows [12] = '{'{8'h00, 32'hff, PAM_RESP_OKAY, 32'hff}, '{8'h04, 32'h07, PAM_RESP_OKAY, 32'h07},
		'{8'h08, 32'h03, PAM_RESP_OKAY, 32'h03}, '{8'h0c, 32'h01, PAM_RESP_OKAY, 32'h01},
		'{8'h10, 32'ha5, PAM_RESP_OKAY, 32'ha5}, '{8'h14, 32'h0f, PAM_RESP_OKAY, 32'h0f},
		'{8'h18, 32'h5a, PAM_RESP_OKAY, 32'h5a}, '{8'h1c, 32'h0f, PAM_RESP_OKAY, 32'h0f},
		'{8'h20, 32'hc3, PAM_RESP_OKAY, 32'hc3}, '{8'h24, 32'hf0, PAM_RESP_OKAY, 32'hf0},
		'{8'h34, 32'h11, PAM_RESP_SLVERR, 32'h0}, '{8'h02, 32'h22, PAM_RESP_SLVERR, 32'h0}};
	pam_mux_top i_pam_mux_top (.sys_clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .processor_clock_output_en,
		.waveform_addr_out, .shared_data_bus_o, .shared_data_bus_oe, .shared_data_bus_i, .timer0_mode,
		.timer0_ovf_full, .timer0_ovf_low, .timer1_mode, .timer1_ovf_full, .timer1_ovf_low, .timer2_ovf,
		.timer_overflow_pulses, .port_c_in, .port_c_out, .port_c_oe, .port_d_in, .port_d_out, .port_d_oe,
		.port_e_in, .port_e_out, .port_e_oe);
	pam_board_port i_pam_board_port_c (.dev_out(port_c_out), .dev_oe(port_c_oe), .ext_val, .ext_en, .pin_level(port_c_in));
	pam_board_port i_pam_board_port_d (.dev_out(port_d_out), .dev_oe(port_d_oe), .ext_val, .ext_en, .pin_level(port_d_in));
	pam_board_port i_pam_board_port_e (.dev_out(port_e_out), .dev_oe(port_e_oe), .ext_val, .ext_en, .pin_level(port_e_in));
	// ------------------------------------------------------------
	// Clocks and tasks
	// ------------------------------------------------------------
	initial forever #2.5 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		ce_cnt <= ce_cnt + 2'h1;
		processor_clock_output_en <= (ce_cnt == 2'h3);
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_mismatch++;
			end_of_test();
		end
	end
	task automatic end_of_test;
		if (n_mismatch == 0 && checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask
	// Slow mode raises the response ready only once the answer shows
	task automatic axi(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic slow);
		logic at, wt, rt, seen, done;
		int n;
		done = 1'h0;
		@(posedge sys_clk);
		s_axi_awaddr <= {24'h0, a};
		s_axi_araddr <= {24'h0, a};
		s_axi_wdata <= d;
		s_axi_awvalid <= wr;
		s_axi_wvalid <= wr;
		s_axi_arvalid <= !wr;
		s_axi_bready <= wr && !slow;
		s_axi_rready <= !wr && !slow;
		for (n = 0; n < 100 && !done; n++) begin
			@(negedge sys_clk);
			at = s_axi_awready;
			wt = s_axi_wready;
			rt = s_axi_arready;
			seen = wr ? s_axi_bvalid : s_axi_rvalid;
			done = seen && (wr ? s_axi_bready : s_axi_rready);
			q = s_axi_rdata;
			r = wr ? s_axi_bresp : s_axi_rresp;
			@(posedge sys_clk);
			if (at) s_axi_awvalid <= 1'h0;
			if (wt) s_axi_wvalid <= 1'h0;
			if (rt) s_axi_arvalid <= 1'h0;
			s_axi_bready <= wr && seen && !done;
			s_axi_rready <= !wr && seen && !done;
		end
		if (!done) check("bus answer", 32'h0, 32'h1);
	endtask
	task automatic fire(input int t, input logic [1:0] m, input logic f, input logic l, input logic e);
		do @(negedge sys_clk); while (!processor_clock_output_en);
		@(posedge sys_clk);
		timer0_mode <= m;
		timer1_mode <= m;
		timer0_ovf_full <= f && t == 0;
		timer0_ovf_low <= l && t == 0;
		timer1_ovf_full <= f && t == 1;
		timer1_ovf_low <= l && t == 1;
		timer2_ovf <= f && t == 2;
		@(posedge sys_clk);
		{timer0_ovf_full, timer0_ovf_low, timer1_ovf_full, timer1_ovf_low, timer2_ovf} <= 5'h00;
		do @(negedge sys_clk); while (!processor_clock_output_en);
		@(negedge sys_clk);
		check("timer pulse", timer_overflow_pulses[t], e);
		check("pin pulse", port_e_out[t], e);
		repeat (3) @(negedge sys_clk);
		check("pulse width", timer_overflow_pulses[t], e);
		@(negedge sys_clk);
		check("pulse end", timer_overflow_pulses[t], 1'h0);
	endtask
	// ------------------------------------------------------------
	// Sequence
	// ------------------------------------------------------------
	initial begin
		repeat (16) @(posedge sys_clk);
		rst <= 1'h0;
		foreach (rows[i]) begin
			axi(1'h1, rows[i].a, rows[i].d, i[0]);
			check("write code", r, rows[i].r);
			axi(1'h0, rows[i].a, 32'h0, !i[0]);
			check("read code", r, rows[i].r);
			check("read data", q, rows[i].q);
		end
		check("port c drive", port_c_out, 8'h3c);
		check("port c enable", port_c_oe, 8'hff);
		check("port d drive", port_d_out, 8'h96);
		check("port d enable", port_d_oe, 8'hff);
		check("bus input", shared_data_bus_i, 8'h96);
		check("port e enable", port_e_oe, 8'hf7);
		check("port e drive", port_e_out[7:3], 5'h18);
		shared_data_bus_oe <= 1'h0;
		ext_en <= 8'hff;
		axi(1'h0, PAM_PIN_D_OFS, 32'h0, 1'h0);
		check("bus released", port_d_oe, 8'h00);
		check("bus read", q, 32'h69);
		ext_en <= 8'hf0;
		rst <= 1'h1;
		repeat (2) @(posedge sys_clk);
		rst <= 1'h0;
		@(negedge sys_clk);
		check("reset enables", {port_c_oe, port_d_oe, port_e_oe}, 32'h0);
		for (int a = 0; a <= 'h24; a += 4) begin
			axi(1'h0, a[7:0], 32'h0, 1'h0);
			check("reset value", q, 32'h0);
		end
		axi(1'h1, PAM_PORT_C_OE_OFS, 32'h0f, 1'h0);
		axi(1'h1, PAM_PORT_C_OUT_OFS, 32'h05, 1'h0);
		axi(1'h0, PAM_PIN_C_OFS, 32'h0, 1'h0);
		check("port c pins", q, 32'h65);
		s_axi_wstrb <= 4'he;
		axi(1'h1, PAM_PORT_C_OE_OFS, 32'hff, 1'h0);
		s_axi_wstrb <= 4'hf;
		axi(1'h0, PAM_PORT_C_OE_OFS, 32'h0, 1'h0);
		check("masked write", q, 32'h0f);
		axi(1'h0, PAM_PIN_E_OFS, 32'h0, 1'h0);
		check("port e pins", q, 32'h6f);
		ext_en <= 8'h00;
		shared_data_bus_oe <= 1'h1;
		axi(1'h1, PAM_ENDPOINT_BUFFER_CONFIG_OFS, 32'h01, 1'h0);
		check("wide only", port_d_oe, 8'h00);
		axi(1'h1, PAM_ENDPOINT_BUFFER_CONFIG_OFS, 32'h00, 1'h0);
		axi(1'h1, PAM_INTERFACE_CONFIG_OFS, 32'h01, 1'h0);
		check("narrow bus", port_d_oe, 8'h00);
		axi(1'h1, PAM_PORT_E_ALT_SELECT_OFS, 32'h07, 1'h0);
		for (int t = 0; t < 2; t++) begin
			fire(t, 2'h0, 1'h1, 1'h0, 1'h1);
			fire(t, 2'h0, 1'h0, 1'h1, 1'h0);
			fire(t, PAM_TIMER_MODE_SPLIT, 1'h0, 1'h1, 1'h1);
			fire(t, PAM_TIMER_MODE_SPLIT, 1'h1, 1'h0, 1'h0);
		end
		fire(2, 2'h0, 1'h1, 1'h0, 1'h1);
		end_of_test();
	end
endmodule // port_alternate_function_mux_tb
